//--- hw/lsd_pkg.sv
// Package: mode register layouts, command codes and field constants
package lsd_pkg;
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int ROW_W = 12;
    localparam int DQ_W = 16;
    localparam int MODE_W = 14;
    localparam int LAT_MAX = 3;
    localparam int MASK_LAT = 2;
    localparam int FULL_PAGE_LEN = 256;
    localparam int BL_LSB = 0;
    localparam int BL_MSB = 2;
    localparam int ORDER_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int LAT_MSB = 6;
    localparam int OPM_LSB = 7;
    localparam int OPM_MSB = 8;
    localparam int WSA_BIT = 9;
    localparam int OPC_MSB = 10;
    localparam int AP_BIT = 10;
    localparam int COV_LSB = 0;
    localparam int COV_MSB = 2;
    localparam int DRV_LSB = 5;
    localparam int DRV_MSB = 6;
    localparam int UPPER_BIT = 7;
    localparam int EXT_Z_LSB = 8;
    localparam int EXT_Z_MSB = 11;
    localparam logic [2:0] BL_ONE = 3'h0;
    localparam logic [2:0] BL_TWO = 3'h1;
    localparam logic [2:0] BL_FOUR = 3'h2;
    localparam logic [2:0] BL_EIGHT = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic [2:0] LAT_ONE = 3'h1;
    localparam logic [2:0] LAT_THREE = 3'h3;
    localparam logic [1:0] OPM_STD = 2'h0;
    localparam logic [2:0] COV_ONE = 3'h2;
    localparam logic [1:0] BANK_EXT = 2'h2;
    localparam logic [MODE_W-1:0] MODE_RST = 14'h0000;
    // Command code {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        LSD_CMD_LOAD = 4'h0,
        LSD_CMD_REF = 4'h1,
        LSD_CMD_PRE = 4'h2,
        LSD_CMD_ACT = 4'h3,
        LSD_CMD_WR = 4'h4,
        LSD_CMD_RD = 4'h5,
        LSD_CMD_BT = 4'h6,
        LSD_CMD_NOP = 4'h7
    } lsd_cmd_t;
    // Command pins grouped as one carrier
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic lower_byte_mask;
        logic upper_byte_mask;
    } lsd_cmd_bus_t;
endpackage

//--- hw/lsd_burst_addr.sv
// Burst column sequencer for sequential and interleaved order
`timescale 1ns/100ps
`default_nettype none
module lsd_burst_addr (
    // Burst setup
    input wire logic [lsd_pkg::COL_W-1:0] start_col,
    input wire logic [2:0] len_code,
    input wire logic interleave,
    input wire logic [lsd_pkg::COL_W-1:0] beat,
    // Column out
    output logic [lsd_pkg::COL_W-1:0] col
);
    import lsd_pkg::*;
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] seq_off;
    // Offset mask per burst length; page wraps over the whole row
    always_comb begin
        unique case (len_code)
            BL_TWO: mask = 8'h01;
            BL_FOUR: mask = 8'h03;
            BL_EIGHT: mask = 8'h07;
            BL_PAGE: mask = 8'hFF;
            default: mask = 8'h00;
        endcase
    end
    // Block bits fixed, offset wraps inside block
    always_comb begin
        seq_off = COL_W'(start_col + beat);
        if (interleave && len_code != BL_PAGE && len_code != BL_ONE) begin
            col = (start_col & ~mask) | ((start_col ^ beat) & mask);
        end else begin
            col = (start_col & ~mask) | (seq_off & mask);
        end
    end
endmodule
`default_nettype wire

//--- hw/lsd_mode_regs.sv
// Base and extended mode registers with field decode
`timescale 1ns/100ps
`default_nettype none
module lsd_mode_regs (
    // Clock and control
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Load strobe
    input wire logic load,
    input wire logic [1:0] bank,
    input wire logic [lsd_pkg::ADDR_W-1:0] addr,
    // Stored registers
    output logic [lsd_pkg::MODE_W-1:0] burst_and_latency_mode_q,
    output logic [lsd_pkg::MODE_W-1:0] low_power_extra_mode_q,
    output logic bad_load_q
);
    import lsd_pkg::*;
    logic [MODE_W-1:0] op;
    assign op = {bank, 1'b0, addr[OPC_MSB:0]};
    // Register writes selected by bank bits
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            burst_and_latency_mode_q <= MODE_RST;
            low_power_extra_mode_q <= MODE_RST;
        end else if (clk_en && load) begin
            if (bank == BANK_EXT) begin
                low_power_extra_mode_q <= op;
            end else begin
                burst_and_latency_mode_q <= op;
            end
        end
    end
    // Reserved code detection on each load
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bad_load_q <= 1'b0;
        end else if (clk_en && load) begin
            if (bank == BANK_EXT) begin
                bad_load_q <= (op[COV_MSB:COV_LSB] > COV_ONE) ||
                    (op[EXT_Z_MSB:EXT_Z_LSB] != 4'h0);
            end else begin
                bad_load_q <= (op[BL_MSB:BL_LSB] > BL_EIGHT &&
                    !(op[BL_MSB:BL_LSB] == BL_PAGE && !op[ORDER_BIT])) ||
                    op[LAT_MSB:LAT_LSB] < LAT_ONE || op[LAT_MSB:LAT_LSB] > LAT_THREE ||
                    op[OPM_MSB:OPM_LSB] != OPM_STD;
            end
        end
    end
endmodule
`default_nettype wire

//--- hw/lsd_cmd_core.sv
// Command decoder and burst control of the low-power SDRAM
// Notes on behaviour
// - Burst length codes 000..011 give 1, 2, 4, 8 locations.
// - Code 111 is full page with sequential order only; others reserved.
// - Sequential adds the count; interleaved XORs start offset with count.
// - Upper column bits fix the block; low bits give the start offset.
// - A burst wraps inside its aligned block.
// - Length one uses column bits 7..0 and ignores order bit.
// - Operating mode bits must be zero; others reserved.
// - Latency field 001, 010, 011 gives one to three clocks.
// - Read at edge r: drive from r+q-1, data valid by r+q.
// - Write single access bit forces single-location writes.
// - Load with banks 1,0 writes the extended register; bits 8..11 zero.
// - Coverage field picks four, two or one bank; bit 7 chooses half.
// - Self refresh keeps only covered banks; normal access unaffected.
// - Extended bits 6..5 set drive strength full to quarter.
// - Self refresh interval tracks internal temperature sensor.
// - Commands decode from select, strobes and write enable.
// - Clock enable high except self refresh and deep sleep; refresh and terminate codes split on it.
// - Refresh uses internal counter row; other inputs ignored.
// - Read/write column from bits 7..0, bit 10 auto precharge; row 11..0.
// - Precharge bit 10 high means all banks, else chosen bank.
// - Byte masks gate writes at once and reads two clocks later.
// - Deselect or no-operation registers nothing new.
// - Mode load takes op-code from address bits 10..0.
`timescale 1ns/100ps
`default_nettype none
module lsd_cmd_core (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Command pins from controller
    input wire lsd_pkg::lsd_cmd_bus_t cmd_pins,
    input wire logic mem_clk_en,
    // Data pins
    input wire logic [lsd_pkg::DQ_W-1:0] dq_in,
    output logic [lsd_pkg::DQ_W-1:0] dq_out,
    output logic [lsd_pkg::DQ_W-1:0] dq_oe,
    // Array access
    output logic arr_wr_q,
    output logic [lsd_pkg::DQ_W-1:0] arr_wdata_q,
    output logic [1:0] arr_byte_en_q,
    output logic [1:0] arr_bank_q,
    output logic [lsd_pkg::COL_W-1:0] arr_col_q,
    input wire logic [lsd_pkg::DQ_W-1:0] arr_rdata,
    output logic act_q,
    output logic [lsd_pkg::ROW_W-1:0] act_row_q,
    output logic pre_q,
    output logic [3:0] pre_banks_q,
    output logic auto_pre_q,
    output logic auto_ref_q,
    input wire logic temp_hot,
    // Low power state
    output logic self_ref_q,
    output logic deep_sleep_mode_q,
    output logic [3:0] keep_banks_q,
    output logic [1:0] drive_strength_q,
    output logic fast_refresh_q,
    output logic bad_load_q
);
    import lsd_pkg::*;
    typedef enum logic [1:0] {
        LSD_IDLE = 2'b00,
        LSD_READ = 2'b01,
        LSD_WRITE = 2'b10
    } lsd_state_t;
    lsd_cmd_bus_t s1_q, s2_q;
    logic cke1_q, cke2_q, hot1_q, hot2_q;
    lsd_state_t state_q;
    logic [MODE_W-1:0] mr, emr;
    logic [COL_W-1:0] beat_q, col_now, start_q;
    logic [1:0] bank_q;
    logic [8:0] left_q;
    logic [2:0] len_q;
    logic order_q, ap_q, burst_wr;
    logic [LAT_MAX-1:0] rd_pipe_q;
    logic [1:0] mask_d1_q;
    logic [DQ_W-1:0] dout_q, rdat_d1_q, rdat_d2_q;
    logic drv_q, drv_d;
    lsd_cmd_t cmd;
    logic sel, cmd_cke;

    // Decode number of beats for a length code
    function automatic logic [8:0] beats(input logic [2:0] code);
        unique case (code)
            BL_TWO: beats = 9'h002;
            BL_FOUR: beats = 9'h004;
            BL_EIGHT: beats = 9'h008;
            BL_PAGE: beats = 9'(FULL_PAGE_LEN);
            default: beats = 9'h001;
        endcase
    endfunction

    // Two-flop synchronisers for pin inputs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_q <= '1;
            s2_q <= '1;
            cke1_q <= 1'b1;
            cke2_q <= 1'b1;
            hot1_q <= 1'b0;
            hot2_q <= 1'b0;
        end else if (clk_en) begin
            s1_q <= cmd_pins;
            s2_q <= s1_q;
            cke1_q <= mem_clk_en;
            cke2_q <= cke1_q;
            hot1_q <= temp_hot;
            hot2_q <= hot1_q;
        end
    end

    // Command decode, deselect gives nothing
    assign cmd = lsd_cmd_t'({s2_q.cs_n, s2_q.ras_n, s2_q.cas_n, s2_q.we_n});
    assign sel = !s2_q.cs_n && !self_ref_q && !deep_sleep_mode_q;
    assign cmd_cke = cke2_q;

    lsd_mode_regs u_modes (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .load(sel && cmd_cke && cmd == LSD_CMD_LOAD),
        .bank(s2_q.bank),
        .addr(s2_q.addr),
        .burst_and_latency_mode_q(mr),
        .low_power_extra_mode_q(emr),
        .bad_load_q(bad_load_q)
    );

    lsd_burst_addr u_burst (
        .start_col(start_q),
        .len_code(len_q),
        .interleave(order_q),
        .beat(beat_q),
        .col(col_now)
    );

    assign burst_wr = !mr[WSA_BIT];

    // Burst state: start, step, wrap, terminate
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= LSD_IDLE;
            beat_q <= 8'h00;
            start_q <= 8'h00;
            bank_q <= 2'h0;
            left_q <= 9'h000;
            len_q <= BL_ONE;
            order_q <= 1'b0;
            ap_q <= 1'b0;
        end else if (clk_en) begin
            if (sel && cmd_cke && (cmd == LSD_CMD_RD || cmd == LSD_CMD_WR)) begin
                state_q <= (cmd == LSD_CMD_RD) ? LSD_READ : LSD_WRITE;
                start_q <= s2_q.addr[COL_W-1:0];
                bank_q <= s2_q.bank;
                beat_q <= 8'h00;
                len_q <= (cmd == LSD_CMD_WR && !burst_wr) ? BL_ONE : mr[BL_MSB:BL_LSB];
                left_q <= (cmd == LSD_CMD_WR && !burst_wr) ? 9'h001 :
                    beats(mr[BL_MSB:BL_LSB]);
                order_q <= mr[ORDER_BIT];
                ap_q <= s2_q.addr[AP_BIT] && mr[BL_MSB:BL_LSB] != BL_PAGE;
            end else if (sel && cmd_cke && cmd == LSD_CMD_BT) begin
                state_q <= LSD_IDLE;
                ap_q <= 1'b0;
            end else if (state_q != LSD_IDLE) begin
                beat_q <= COL_W'(beat_q + 8'h01);
                if (left_q == 9'h001 && len_q != BL_PAGE) begin
                    state_q <= LSD_IDLE;
                    ap_q <= 1'b0;
                end else begin
                    left_q <= 9'(left_q - 9'h001);
                end
            end
        end
    end

    // Array strobes for each beat, write masks same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            arr_wr_q <= 1'b0;
            arr_wdata_q <= 16'h0000;
            arr_byte_en_q <= 2'h0;
            arr_bank_q <= 2'h0;
            arr_col_q <= 8'h00;
            auto_pre_q <= 1'b0;
        end else if (clk_en) begin
            arr_wr_q <= (state_q == LSD_WRITE);
            arr_wdata_q <= dq_in;
            arr_byte_en_q <= ~{s2_q.upper_byte_mask, s2_q.lower_byte_mask};
            arr_bank_q <= bank_q;
            arr_col_q <= col_now;
            auto_pre_q <= ap_q && state_q != LSD_IDLE && left_q == 9'h001;
        end
    end

    // Activate, precharge, refresh strobes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            act_q <= 1'b0;
            act_row_q <= 12'h000;
            pre_q <= 1'b0;
            pre_banks_q <= 4'h0;
            auto_ref_q <= 1'b0;
        end else if (clk_en) begin
            act_q <= sel && cmd_cke && cmd == LSD_CMD_ACT;
            act_row_q <= s2_q.addr;
            pre_q <= sel && cmd_cke && cmd == LSD_CMD_PRE;
            pre_banks_q <= s2_q.addr[AP_BIT] ? 4'hF : 4'(1 << s2_q.bank);
            auto_ref_q <= sel && cmd_cke && cmd == LSD_CMD_REF;
        end
    end

    // Self refresh and deep sleep entry and exit on clock enable
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            self_ref_q <= 1'b0;
            deep_sleep_mode_q <= 1'b0;
        end else if (clk_en) begin
            if (cke2_q) begin
                self_ref_q <= 1'b0;
                deep_sleep_mode_q <= 1'b0;
            end else if (sel && cmd == LSD_CMD_REF) begin
                self_ref_q <= 1'b1;
            end else if (sel && cmd == LSD_CMD_BT) begin
                deep_sleep_mode_q <= 1'b1;
            end
        end
    end

    // Banks kept during self refresh, drive and temperature
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            keep_banks_q <= 4'hF;
            drive_strength_q <= 2'h0;
            fast_refresh_q <= 1'b0;
        end else if (clk_en) begin
            unique case (emr[COV_MSB:COV_LSB])
                3'h1: keep_banks_q <= emr[UPPER_BIT] ? 4'hC : 4'h3;
                3'h2: keep_banks_q <= emr[UPPER_BIT] ? 4'h4 : 4'h1;
                default: keep_banks_q <= 4'hF;
            endcase
            drive_strength_q <= emr[DRV_MSB:DRV_LSB];
            fast_refresh_q <= self_ref_q && hot2_q;
        end
    end

    // Read latency pipe and delayed byte masks
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_pipe_q <= '0;
            mask_d1_q <= 2'h0;
        end else if (clk_en) begin
            rd_pipe_q <= {rd_pipe_q[LAT_MAX-2:0], state_q == LSD_READ};
            mask_d1_q <= {s2_q.upper_byte_mask, s2_q.lower_byte_mask};
        end
    end

    // Drive enable picked from the read pipe by latency
    always_comb begin
        unique case (mr[LAT_MSB:LAT_LSB])
            LAT_ONE: drv_d = rd_pipe_q[0];
            LAT_THREE: drv_d = rd_pipe_q[2];
            default: drv_d = rd_pipe_q[1];
        endcase
    end

    // Read data delayed to match the drive window
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            drv_q <= 1'b0;
            dout_q <= 16'h0000;
            rdat_d1_q <= 16'h0000;
            rdat_d2_q <= 16'h0000;
            dq_oe <= 16'h0000;
        end else if (clk_en) begin
            drv_q <= drv_d;
            rdat_d1_q <= arr_rdata;
            rdat_d2_q <= rdat_d1_q;
            unique case (mr[LAT_MSB:LAT_LSB])
                LAT_ONE: dout_q <= arr_rdata;
                LAT_THREE: dout_q <= rdat_d2_q;
                default: dout_q <= rdat_d1_q;
            endcase
            dq_oe <= {{8{drv_d && !mask_d1_q[1]}}, {8{drv_d && !mask_d1_q[0]}}};
        end
    end

    assign dq_out = dout_q;
    burst_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_q != LSD_IDLE && len_q == BL_FOUR |->
        (col_now[COL_W-1:2] == start_q[COL_W-1:2]))
        else $error("burst left its block");
    single_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && sel && cmd_cke && cmd == LSD_CMD_WR && mr[WSA_BIT] |=> len_q == BL_ONE)
        else $error("write burst not single");
    prech_all_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && sel && cmd_cke && cmd == LSD_CMD_PRE && s2_q.addr[AP_BIT]
        |=> pre_q && pre_banks_q == 4'hF)
        else $error("precharge all missed");
    deselect_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && s2_q.cs_n |=> !act_q && !pre_q && !auto_ref_q)
        else $error("deselected command acted");
    self_ref_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && sel && !cke2_q && cmd == LSD_CMD_REF |=> self_ref_q && !auto_ref_q)
        else $error("self refresh entry wrong");
    act_row_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && sel && cmd_cke && cmd == LSD_CMD_ACT |=> act_row_q == $past(s2_q.addr))
        else $error("row not captured");
    read_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en ##1 clk_en ##1 clk_en && drv_q && $past(s2_q.lower_byte_mask, 2)
        |-> dq_oe[0] == 1'b0)
        else $error("read mask latency wrong");
    coverage_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && emr[COV_MSB:COV_LSB] == COV_ONE |=> keep_banks_q[0] | keep_banks_q[2])
        else $error("coverage decode wrong");
    cv_read: cover property (@(posedge sys_clk) state_q == LSD_READ ##1 drv_q);
    cv_write: cover property (@(posedge sys_clk) arr_wr_q);
    cv_self: cover property (@(posedge sys_clk) self_ref_q);
endmodule
`default_nettype wire

//--- sim/lsd_ctrl_model.sv
// Memory controller model driving the command pins of the SDRAM block
`timescale 1ns/100ps
`default_nettype none
module lsd_ctrl_model
    import lsd_pkg::*;
#(
    parameter int MRD_CYC = 2
) (
    // Clock
    input wire logic sys_clk,
    // Command pins
    output var lsd_pkg::lsd_cmd_bus_t cmd_pins,
    output var logic mem_clk_en
);
    lsd_cmd_bus_t pend_v;
    logic pend = 1'b0;
    logic cke_v = 1'b1;

    // Deselected bank and address lines toggle every cycle so stale values are never seen; strobes and masks hold
    initial begin
        cmd_pins = {4'hF, 2'h0, 12'h5A5, 2'h0};
        mem_clk_en = 1'b1;
    end

    // One command per request, deselect otherwise
    always @(posedge sys_clk) begin
        #1;
        if (pend) begin
            cmd_pins = pend_v;
            mem_clk_en = cke_v;
            pend = 1'b0;
        end else begin
            cmd_pins.cs_n = 1'b1;
            cmd_pins.bank = ~cmd_pins.bank;
            cmd_pins.addr = ~cmd_pins.addr;
        end
    end

    // Command held for exactly one sampling edge
    task automatic issue(input logic [3:0] code, input logic [1:0] bank,
                         input logic [11:0] addr, input logic [1:0] mask, input logic cke);
        pend_v = {code, bank, addr, mask[0], mask[1]};
        cke_v = cke;
        pend = 1'b1;
        wait (!pend);
        @(posedge sys_clk);
    endtask

    // Mode load with must-be-zero bits cleared, then the settling gap
    task automatic load(input logic ext, input logic [11:0] op);
        logic [11:0] a;
        a = op;
        if (ext) begin
            a[EXT_Z_MSB:EXT_Z_LSB] = 4'h0;
            a[4:3] = 2'h0;
        end else begin
            a[OPM_MSB:OPM_LSB] = OPM_STD;
            a[11:10] = 2'h0;
        end
        issue(LSD_CMD_LOAD, ext ? BANK_EXT : 2'h0, a, 2'h0, 1'b1);
        repeat (MRD_CYC) issue(LSD_CMD_NOP, 2'h0, 12'h000, 2'h0, 1'b1);
    endtask

    // Power-up order: precharge all, then two auto refreshes
    task automatic init();
        issue(LSD_CMD_PRE, 2'h0, 12'h400, 2'h0, 1'b1);
        repeat (2) issue(LSD_CMD_REF, 2'h0, 12'h000, 2'h0, 1'b1);
    endtask
endmodule
`default_nettype wire

//--- sim/lsd_cmd_core_tb.sv
// Self-checking bench of the SDRAM command block
`timescale 1ns/100ps
`default_nettype none
module lsd_cmd_core_tb;
    import lsd_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic temp_hot = 1'b0;
    logic [15:0] dq_in = 16'h0000;
    lsd_cmd_bus_t cmd_pins;
    logic mem_clk_en, arr_wr_q, act_q, pre_q, auto_pre_q, auto_ref_q, self_ref_q;
    logic deep_sleep_mode_q, fast_refresh_q, bad_load_q;
    logic [15:0] dq_out, dq_oe, arr_wdata_q, arr_rdata;
    logic [1:0] arr_byte_en_q, arr_bank_q, drive_strength_q;
    logic [7:0] arr_col_q;
    logic [11:0] act_row_q;
    logic [3:0] pre_banks_q, keep_banks_q;
    int err_count = 0;
    int n_checks = 0;
    int ref_seen = 0, ref_exp = 0, ap_seen = 0, ap_exp = 0;
    logic [31:0] wq[$], aq[$], pq[$], rq[$];
    logic [12:0] wt[5] = '{13'h0E1D, 13'h0245, 13'h0833, 13'h04A6, 13'h0D2B};
    logic [12:0] rt[6] = '{13'h0024, 13'h002F, 13'h0002, 13'h0042, 13'h1003, 13'h1004};
    logic [3:0] kbt[4] = '{4'hF, 4'hC, 4'h1, 4'hF};

    // Clock and array read model
    always #25 sys_clk = ~sys_clk;
    assign arr_rdata = {~arr_col_q, arr_col_q};

    lsd_ctrl_model i_ctrl (.sys_clk(sys_clk), .cmd_pins(cmd_pins), .mem_clk_en(mem_clk_en));
    lsd_cmd_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .cmd_pins(cmd_pins),
        .mem_clk_en(mem_clk_en), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .arr_wr_q(arr_wr_q), .arr_wdata_q(arr_wdata_q), .arr_byte_en_q(arr_byte_en_q),
        .arr_bank_q(arr_bank_q), .arr_col_q(arr_col_q), .arr_rdata(arr_rdata),
        .act_q(act_q), .act_row_q(act_row_q), .pre_q(pre_q), .pre_banks_q(pre_banks_q),
        .auto_pre_q(auto_pre_q), .auto_ref_q(auto_ref_q), .temp_hot(temp_hot),
        .self_ref_q(self_ref_q), .deep_sleep_mode_q(deep_sleep_mode_q),
        .keep_banks_q(keep_banks_q), .drive_strength_q(drive_strength_q),
        .fast_refresh_q(fast_refresh_q), .bad_load_q(bad_load_q));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pop(input string what, ref logic [31:0] q[$], input logic [31:0] got);
        if (q.size() == 0) chk({what, " unexpected"}, 32'h0, 32'h1);
        else chk(what, q.pop_front(), got);
    endtask

    // Expected column of beat i inside the aligned block
    function automatic logic [7:0] bcol(input logic [7:0] s, input logic [2:0] bl,
                                        input logic il, input logic [7:0] i);
        logic [7:0] m;
        m = (8'h01 << bl) - 8'h01;
        return il ? ((s & ~m) | ((s ^ i) & m)) : ((s & ~m) | ((s + i) & m));
    endfunction

    task automatic drain();
        for (int i = 0; i < 60 && (wq.size() + aq.size() + pq.size() + rq.size()) > 0; i++)
            @(posedge sys_clk);
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Watcher: each write, activate, precharge and read takes the oldest note of its kind; refreshes and auto precharges are counted
    always @(negedge sys_clk) begin
        if (rst_n === 1'b1) begin
            if (arr_wr_q === 1'b1)
                pop("write", wq, {4'h0, arr_bank_q, arr_byte_en_q, arr_col_q, arr_wdata_q});
            if (act_q === 1'b1) pop("activate", aq, {20'h0, act_row_q});
            if (pre_q === 1'b1) pop("precharge", pq, {28'h0, pre_banks_q});
            if (dq_oe !== 16'h0000) pop("read", rq, {dq_oe, dq_out & dq_oe});
            if (auto_ref_q === 1'b1) ref_seen++;
            if (auto_pre_q === 1'b1) ap_seen++;
        end
    end

    // Watchdog
    initial begin
        #(50 * 20000);
        err_count++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        logic [7:0] col;
        logic [1:0] m, bk;
        logic [11:0] r;
        logic [2:0] bl;
        logic il, ws;
        int n[4];
        void'($urandom(32'hC80EF7B5));
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("reset keep", 32'hF, {28'h0, keep_banks_q});
        pq.push_back(32'hF);
        ref_exp += 2;
        i_ctrl.init();
        drain();
        $display("init done");
        // Extended register: every drive strength, coverage of both halves
        for (int i = 0; i < 4; i++) begin
            #1 temp_hot = 1'($urandom);
            i_ctrl.load(1'b1, {4'h0, i[0], i[1:0], 2'h0, 3'(i % 3)});
            repeat (6) @(posedge sys_clk);
            chk("drive", 32'(i), {30'h0, drive_strength_q});
            chk("keep", {28'h0, kbt[i]}, {28'h0, keep_banks_q});
        end
        $display("extended done");
        // Write bursts over lengths, orders, block edges and single mode
        foreach (wt[k]) begin
            {bl, il, ws, col} = wt[k];
            i_ctrl.load(1'b0, (12'(ws) << WSA_BIT) | 12'h020 | (12'(il) << ORDER_BIT) | 12'(bl));
            m = 2'($urandom % 3);
            r = (12'($urandom) & 12'h400) | 12'(col);
            bk = 2'($urandom);
            #1 dq_in = 16'($urandom);
            ap_exp += int'(r[AP_BIT]);
            for (int i = 0; i < (ws ? 1 : 1 << bl); i++)
                wq.push_back({4'h0, bk, ~m[1], ~m[0], bcol(col, bl, il, 8'(i)), dq_in});
            i_ctrl.issue(LSD_CMD_WR, bk, r, m, 1'b1);
            drain();
        end
        $display("writes done");
        // Interleaved reads at each latency, lower byte masked at latency one, upper at two, none at three
        for (int q = 1; q < 4; q++) begin
            i_ctrl.load(1'b0, (12'(q) << LAT_LSB) | 12'h00A);
            m = 2'(q % 3);
            for (int i = 0; i < 4; i++) begin
                col = bcol(8'h45, BL_FOUR, 1'b1, 8'(i));
                rq.push_back({{8{~m[1]}}, {8{~m[0]}}, {~col, col} & {{8{~m[1]}}, {8{~m[0]}}}});
            end
            i_ctrl.issue(LSD_CMD_NOP, 2'h0, 12'h000, m, 1'b1);
            i_ctrl.issue(LSD_CMD_RD, 2'h1, 12'h045, m, 1'b1);
            n[q] = 0;
            while (dq_oe === 16'h0000 && n[q] < 40) begin
                @(negedge sys_clk);
                n[q]++;
            end
            drain();
        end
        chk("latency step", 32'h1, 32'(n[2] - n[1]));
        chk("latency step", 32'h1, 32'(n[3] - n[2]));
        $display("reads done");
        // Precharge each bank and all banks, activations, ignored commands
        for (int b = 0; b < 5; b++) begin
            pq.push_back(b == 4 ? 32'hF : 32'h1 << b);
            r = b == 4 ? (12'($urandom) | 12'h400) : (12'($urandom) & 12'hBFF);
            i_ctrl.issue(LSD_CMD_PRE, b == 4 ? 2'($urandom) : 2'(b), r, 2'h0, 1'b1);
            r = 12'($urandom);
            aq.push_back({20'h0, r});
            i_ctrl.issue(LSD_CMD_ACT, 2'($urandom), r, 2'h0, 1'b1);
        end
        i_ctrl.issue(4'hB, 2'h1, 12'h3C3, 2'h0, 1'b1);
        i_ctrl.issue(LSD_CMD_NOP, 2'h2, 12'($urandom), 2'h0, 1'b1);
        ref_exp++;
        i_ctrl.issue(LSD_CMD_REF, 2'($urandom), 12'($urandom), 2'($urandom), 1'b1);
        drain();
        $display("row commands done");
        // Full page sequential is accepted, reserved codes raise the flag
        i_ctrl.load(1'b0, 12'h027);
        repeat (6) @(posedge sys_clk);
        chk("valid flag", 32'h0, {31'h0, bad_load_q});
        foreach (rt[k]) begin
            i_ctrl.load(rt[k][12], rt[k][11:0]);
            repeat (6) @(posedge sys_clk);
            chk("reserved flag", 32'h1, {31'h0, bad_load_q});
            i_ctrl.load(1'b0, 12'h022);
        end
        $display("reserved done");
        // Self refresh and deep sleep entered with clock enable low
        #1 temp_hot = 1'b1;
        for (int k = 0; k < 2; k++) begin
            i_ctrl.issue(k ? LSD_CMD_BT : LSD_CMD_REF, 2'h0, 12'h000, 2'h0, 1'b0);
            repeat (4) @(posedge sys_clk);
            i_ctrl.issue(LSD_CMD_ACT, 2'h0, 12'h123, 2'h0, 1'b0);
            repeat (6) @(posedge sys_clk);
            chk("low power", 32'h1, {31'h0, k ? deep_sleep_mode_q : self_ref_q});
            chk("fast refresh", {31'h0, ~k[0]}, {31'h0, fast_refresh_q});
            i_ctrl.issue(LSD_CMD_NOP, 2'h0, 12'h000, 2'h0, 1'b1);
            repeat (6) @(posedge sys_clk);
            chk("awake", 32'h0, {31'h0, k ? deep_sleep_mode_q : self_ref_q});
        end
        $display("low power done");
        chk("refresh count", 32'(ref_exp), 32'(ref_seen));
        chk("auto precharge count", 32'(ap_exp), 32'(ap_seen));
        stop_test();
    end
endmodule
`default_nettype wire
